// ### inc/btag_params.svh
`ifndef BTAG_PARAMS_SVH
`define BTAG_PARAMS_SVH
`define BTAG_PC_RESET       16'h0000
`define BTAG_TABLE_BASE     16'h0040
`define BTAG_TABLE_LAST     16'h007f
`define BTAG_IDX_LSB        1
`define BTAG_IDX_MSB        5
`define BTAG_DISP_SIGN      7
`define BTAG_ADDR_RESET     16'h0000
`define BTAG_BYTE_RESET     8'h00
`define BTAG_FLAG_RESET     1'h0
`define BTAG_ENTRY_STEP     16'h0001
`endif

// ### inc/btag_pkg.sv
package btag_pkg;
  typedef enum logic [5:0] {
    BTAG_SRC_SEQ   = 6'h01,
    BTAG_SRC_REL   = 6'h02,
    BTAG_SRC_IMM   = 6'h04,
    BTAG_SRC_TABLE = 6'h08,
    BTAG_SRC_ACC   = 6'h10,
    BTAG_SRC_HOLD  = 6'h20
  } btag_src_e;

  typedef enum logic [1:0] {
    BTAG_ST_IDLE = 2'h1,
    BTAG_ST_VECT = 2'h2
  } btag_state_e;

  typedef struct packed {
    logic        valid;
    btag_src_e   src;
    logic [2:0]  length;
    logic [7:0]  jump_displacement;
    logic [15:0] imm16;
    logic [7:0]  opcode;
  } btag_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } btag_mem_s;
endpackage : btag_pkg

// ### core/btag_next_pc.sv
`timescale 1ns/1ps
`include "btag_params.svh"
module btag_next_pc (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire btag_pkg::btag_req_s req,
  input  wire logic [15:0]       accumulator_pair,
  input  wire btag_pkg::btag_mem_s direct_req,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_valid,
  output logic [15:0]            pc,
  output logic                   busy,
  output logic                   done,
  output logic                   vec_rd,
  output logic [15:0]            vec_addr,
  output logic                   data_rd,
  output logic [15:0]            data_addr
);
  logic [15:0]            pc_r;
  logic [15:0]            pc_nxt;
  logic                   busy_r;
  logic                   busy_nxt;
  logic                   done_r;
  logic                   done_nxt;
  logic                   vec_rd_r;
  logic                   vec_rd_nxt;
  logic [15:0]            vec_addr_r;
  logic [15:0]            vec_addr_nxt;
  logic                   data_rd_r;
  logic                   data_rd_nxt;
  logic [15:0]            data_addr_r;
  logic [15:0]            data_addr_nxt;
  logic                   hi_phase_r;
  logic                   hi_phase_nxt;
  logic [7:0]             lo_byte_r;
  logic [7:0]             lo_byte_nxt;
  btag_pkg::btag_state_e  state_r;
  btag_pkg::btag_state_e  state_nxt;

  wire                    in_idle;
  wire                    in_vect;
  wire                    take;
  wire                    pick_seq;
  wire                    pick_rel;
  wire                    pick_imm;
  wire                    pick_acc;
  wire                    start_tbl;
  wire                    finish_pc;
  wire                    lo_arrive;
  wire                    hi_arrive;
  wire [15:0]             seq_pc;
  wire [15:0]             disp_ext;
  wire [15:0]             rel_pc;
  wire [15:0]             tbl_addr;
  wire [15:0]             vec_pc;

  function automatic logic [15:0] btag_table_addr(input logic [7:0] op);
    logic [4:0] idx;
    idx = op[`BTAG_IDX_MSB:`BTAG_IDX_LSB];
    // Entry stays inside the 40H..7FH window for every index
    btag_table_addr = `BTAG_TABLE_BASE | {10'h000, idx, 1'h0};
  endfunction : btag_table_addr

  function automatic logic btag_src_hit(input btag_pkg::btag_req_s r,
                                        input btag_pkg::btag_src_e s);
    btag_src_hit = r.valid && (r.src == s);
  endfunction : btag_src_hit

  // Requests offered while a vector fetch runs are dropped, not queued
  assign in_idle   = (state_r == btag_pkg::BTAG_ST_IDLE);
  assign in_vect   = (state_r == btag_pkg::BTAG_ST_VECT);
  assign take      = req.valid && in_idle;
  assign pick_seq  = in_idle && btag_src_hit(req, btag_pkg::BTAG_SRC_SEQ);
  assign pick_rel  = in_idle && btag_src_hit(req, btag_pkg::BTAG_SRC_REL);
  assign pick_imm  = in_idle && btag_src_hit(req, btag_pkg::BTAG_SRC_IMM);
  assign pick_acc  = in_idle && btag_src_hit(req, btag_pkg::BTAG_SRC_ACC);
  assign start_tbl = in_idle && btag_src_hit(req, btag_pkg::BTAG_SRC_TABLE);
  assign finish_pc = take && !start_tbl;
  assign lo_arrive = in_vect && rd_valid && !hi_phase_r;
  assign hi_arrive = in_vect && rd_valid && hi_phase_r;
  assign seq_pc    = pc_r + {13'h0000, req.length};
  assign disp_ext  = {{8{req.jump_displacement[`BTAG_DISP_SIGN]}},
                      req.jump_displacement};
  assign rel_pc    = seq_pc + disp_ext;
  assign tbl_addr  = btag_table_addr(req.opcode);
  // Low byte is parked so PC moves to the whole vector in one step
  assign vec_pc    = {rd_data, lo_byte_r};

  assign pc_nxt = pick_seq  ? seq_pc           :
                  pick_rel  ? rel_pc           :
                  pick_imm  ? req.imm16        :
                  pick_acc  ? accumulator_pair :
                  hi_arrive ? vec_pc           :
                  pc_r;

  // Vector fetch takes two byte reads; the caller must hold off new requests while busy
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      btag_pkg::BTAG_ST_IDLE: begin
        if (start_tbl) begin
          state_nxt = btag_pkg::BTAG_ST_VECT;
        end
      end
      btag_pkg::BTAG_ST_VECT: begin
        if (hi_arrive) begin
          state_nxt = btag_pkg::BTAG_ST_IDLE;
        end
      end
      default: state_nxt = btag_pkg::BTAG_ST_IDLE;
    endcase
  end

  // Busy is registered from the next state so the pin comes from a flop
  assign busy_nxt      = (state_nxt == btag_pkg::BTAG_ST_VECT);
  assign done_nxt      = finish_pc || hi_arrive;
  assign vec_rd_nxt    = start_tbl ? 1'h1 :
                         hi_arrive ? 1'h0 :
                         vec_rd_r;
  assign vec_addr_nxt  = start_tbl ? tbl_addr :
                         lo_arrive ? vec_addr_r + `BTAG_ENTRY_STEP :
                         vec_addr_r;
  assign hi_phase_nxt  = lo_arrive ? 1'h1 :
                         (start_tbl || hi_arrive) ? 1'h0 :
                         hi_phase_r;
  assign lo_byte_nxt   = lo_arrive ? rd_data : lo_byte_r;
  assign data_rd_nxt   = direct_req.valid;
  assign data_addr_nxt = direct_req.valid ? direct_req.addr : data_addr_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_r <= `BTAG_PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_r <= `BTAG_FLAG_RESET;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_r <= `BTAG_FLAG_RESET;
    end else begin
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      vec_rd_r <= `BTAG_FLAG_RESET;
    end else begin
      vec_rd_r <= vec_rd_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      vec_addr_r <= `BTAG_ADDR_RESET;
    end else begin
      vec_addr_r <= vec_addr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_rd_r <= `BTAG_FLAG_RESET;
    end else begin
      data_rd_r <= data_rd_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_addr_r <= `BTAG_ADDR_RESET;
    end else begin
      data_addr_r <= data_addr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hi_phase_r <= `BTAG_FLAG_RESET;
    end else begin
      hi_phase_r <= hi_phase_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lo_byte_r <= `BTAG_BYTE_RESET;
    end else begin
      lo_byte_r <= lo_byte_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= btag_pkg::BTAG_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pc        = pc_r;
  assign busy      = busy_r;
  assign done      = done_r;
  assign vec_rd    = vec_rd_r;
  assign vec_addr  = vec_addr_r;
  assign data_rd   = data_rd_r;
  assign data_addr = data_addr_r;
endmodule : btag_next_pc

// ### verification/btag_next_pc_asserts.sv
`timescale 1ns/1ps
module btag_chk (
  input wire logic              clk,
  input wire logic              rstn,
  input wire btag_pkg::btag_req_s req,
  input wire logic [15:0]       accumulator_pair,
  input wire btag_pkg::btag_mem_s direct_req,
  input wire logic              rd_valid,
  input wire logic [15:0]       pc,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              vec_rd,
  input wire logic [15:0]       vec_addr,
  input wire logic              data_rd,
  input wire logic [15:0]       data_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire tk = req.valid && !busy;
  wire [15:0] nx = pc + 16'(req.length);
  wire [15:0] rel = nx + {{8{req.jump_displacement[7]}}, req.jump_displacement};
  wire [15:0] va = 16'h0040 + {10'h000, req.opcode[5:1], 1'b0};
  chk_seq_advance: assert property (tk && req.src == btag_pkg::BTAG_SRC_SEQ
    |=> done && pc == $past(nx)) else $error("sequential pc wrong");
  chk_rel_target: assert property (tk && req.src == btag_pkg::BTAG_SRC_REL
    |=> pc == $past(rel)) else $error("relative pc wrong");
  chk_imm_load: assert property (tk && req.src == btag_pkg::BTAG_SRC_IMM
    |=> pc == $past(req.imm16)) else $error("immediate pc wrong");
  chk_acc_load: assert property (tk && req.src == btag_pkg::BTAG_SRC_ACC
    |=> pc == $past(accumulator_pair)) else $error("accumulator pc wrong");
  chk_vec_first: assert property (tk && req.src == btag_pkg::BTAG_SRC_TABLE
    |=> vec_rd && busy && vec_addr == $past(va)) else $error("vector address wrong");
  chk_vec_range: assert property (vec_rd |-> vec_addr >= 16'h0040 && vec_addr <= 16'h007f)
    else $error("vector outside table");
  chk_direct_addr: assert property (direct_req.valid
    |=> data_rd && data_addr == $past(direct_req.addr)) else $error("direct access wrong");
  chk_busy_hold: assert property (busy && !rd_valid |=> $stable(pc))
    else $error("pc moved during fetch");
  cover property (tk && req.src == btag_pkg::BTAG_SRC_REL);
  cover property (busy ##1 !busy);
  cover property (direct_req.valid ##1 data_rd);
endmodule : btag_chk
bind btag_next_pc btag_chk u_chk (.*);

// ### verification/btag_next_pc_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module btag_next_pc_tb;
  typedef struct packed {logic [5:0] s; logic [2:0] l; logic [7:0] d; logic [15:0] i, e;} btag_row_s;
  localparam btag_row_s ROWS [7] = '{'{6'h01, 3'h3, 8'h00, 16'h0000, 16'h0003},
    '{6'h01, 3'h1, 8'h00, 16'h0000, 16'h0004}, '{6'h02, 3'h2, 8'h7f, 16'h0000, 16'h0085},
    '{6'h02, 3'h2, 8'h80, 16'h0000, 16'h0007}, '{6'h04, 3'h3, 8'h00, 16'habcd, 16'habcd},
    '{6'h10, 3'h1, 8'h00, 16'h8421, 16'h8421}, '{6'h20, 3'h1, 8'h00, 16'h0000, 16'h8421}};
  logic clk = 0, rstn = 0, rd_valid = 0, busy, done, vec_rd, data_rd;
  logic [15:0] accumulator_pair = '0, pc, vec_addr, data_addr;
  logic [7:0] rd_data = '0;
  btag_pkg::btag_req_s req = '0;
  btag_pkg::btag_mem_s direct_req = '0;
  int errors = 0, samples_checked = 0, cyc = 0;
  btag_next_pc u_btag_next_pc (.*);
  always #2 clk = ~clk;
  // Ceiling well above the few dozen cycles the tests need
  always @(posedge clk) if (++cyc == 2000) begin errors++; print_verdict(); end
  task automatic tick(); @(posedge clk); #1; endtask : tick
  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) tick();
    rstn = 1;
    foreach (ROWS[k]) begin
      req = '{1'b1, btag_pkg::btag_src_e'(ROWS[k].s), ROWS[k].l, ROWS[k].d, ROWS[k].i, 8'h00};
      accumulator_pair = ROWS[k].i;
      tick();
      `CHK(pc, ROWS[k].e)
      `CHK(done, 1'b1)
    end
    $display("rows end");
    // Top index gives the last entry, and an immediate offered while busy must be dropped
    req = '{1'b1, btag_pkg::BTAG_SRC_TABLE, 3'h1, 8'h00, 16'hffff, 8'h3e};
    tick();
    `CHK(vec_addr, 16'h007e)
    req.src = btag_pkg::BTAG_SRC_IMM;
    tick();
    `CHK({pc, busy, vec_rd}, 18'h21087)
    rd_data = 8'h5a;
    rd_valid = 1;
    tick();
    `CHK(vec_addr, 16'h007f)
    req.valid = 0;
    rd_data = 8'hc3;
    tick();
    rd_valid = 0;
    for (int n = 0; n < 4 && done !== 1'b1; n++) tick();
    `CHK(pc, 16'hc35a)
    `CHK({done, busy, vec_rd}, 3'h4)
    $display("table end");
    direct_req = '{1'b1, 16'hbeef};
    tick();
    direct_req.valid = 0;
    `CHK(data_addr, 16'hbeef)
    `CHK(data_rd, 1'b1)
    rstn = 0;
    tick();
    `CHK({pc, vec_addr, data_addr, busy, done, vec_rd, data_rd}, 52'h0)
    rstn = 1;
    req = '{1'b1, btag_pkg::BTAG_SRC_SEQ, 3'h2, 8'h00, 16'h0000, 8'h00};
    tick();
    `CHK({pc, done}, 17'h00005)
    $display("direct and reset end");
    print_verdict();
  end
endmodule : btag_next_pc_tb
